// ---- inc/iic_pkg.sv ----
// Purpose: Shared constants, carriers and helpers for the input interrupt
//          control block.
// Assumes: One 20 MHz core clock; AXI4-Lite register access, 32-bit data.
// Notes:   Functional notes below; offsets are byte addresses.
//
// Functional notes
// R1 - Three enables pick the source; none set, or change plus channel, disables.
// R2 - Change-detect alone: any masked input level change raises a request.
// R3 - Input 0 enable without change-detect: rising edge of input 0 interrupts.
// R4 - Input 1 enable without change-detect: rising edge of input 1 interrupts.
// R5 - Writing one to change-detect clear drops the change request.
// R6 - Writing one to input 0 clear drops the input 0 rise request.
// R7 - Writing one to input 1 clear drops the input 1 rise request.
// R8 - Writing zero to a clear bit leaves that request untouched.
// R9 - One flag per source reads one while its request is asserted.
// R10 - A change request captures input levels; clearing it erases capture.
// R11 - Inputs sampled at 8.25 MHz; pulses must exceed 122 ns.
// R12 - Per-channel change mask: one includes a channel, zero excludes it.
// R13 - The interrupt line is the OR of the asserted source flags; the code ORs only the flags enabled in irq_mask_reg.
package iic_pkg;

   // ==========================================================
   // Sizes
   localparam int IIC_ADDR_W = 8;
   localparam int IIC_DATA_W = 32;
   localparam int IIC_INPUTS = 16;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] IIC_OFF_CTRL = 8'h00;
   localparam logic [7:0] IIC_OFF_CLEAR = 8'h04;
   localparam logic [7:0] IIC_OFF_FLAGS = 8'h08;
   localparam logic [7:0] IIC_OFF_CHG_MASK = 8'h0C;
   localparam logic [7:0] IIC_OFF_CAPTURE = 8'h10;
   localparam logic [7:0] IIC_OFF_LEVEL = 8'h14;
   localparam logic [7:0] IIC_OFF_IRQ_MASK = 8'h18;
   localparam logic [7:0] IIC_OFF_IRQ_EVENT = 8'h1C;

   // ==========================================================
   // Reset values and responses
   localparam logic [2:0] IIC_CTRL_RESET = 3'h0;
   localparam logic [2:0] IIC_IRQ_MASK_RESET = 3'h7;
   localparam logic [1:0] IIC_RESP_OKAY = 2'h0;
   localparam logic [1:0] IIC_RESP_SLVERR = 2'h2;

   // ==========================================================
   // Timing
   localparam int IIC_CLK_KHZ = 20000;
   localparam int IIC_SAMPLE_KHZ = 8250;
   localparam int IIC_CLK_PERIOD_NS = 50;
   localparam int IIC_MIN_PULSE_NS = 122;
   localparam int IIC_MIN_PULSE_CYC =
      (IIC_MIN_PULSE_NS + IIC_CLK_PERIOD_NS - 1) / IIC_CLK_PERIOD_NS;
   localparam int IIC_PHASE_W = 17;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic input1;
      logic input0;
      logic change;
   } iic_src_type;

   typedef struct packed {
      logic [IIC_ADDR_W-1:0] addr;
      logic [IIC_DATA_W-1:0] data;
      logic [3:0] strb;
   } iic_wr_type;

   // ==========================================================
   // Helpers
   function automatic logic [IIC_DATA_W-1:0] iic_apply_strb(
      input logic [IIC_DATA_W-1:0] old_val,
      input logic [IIC_DATA_W-1:0] new_val,
      input logic [3:0] strb);
      logic [IIC_DATA_W-1:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
      return res;
   endfunction : iic_apply_strb

   // Combined change and channel enables are illegal and act as disabled
   function automatic iic_src_type iic_decode_mode(input iic_src_type en);
      iic_src_type res;
      res = en;
      if (en.change && (en.input0 || en.input1)) begin
         res = '0;
      end
      return res;
   endfunction : iic_decode_mode

   function automatic logic iic_hit(input logic [IIC_ADDR_W-1:0] addr,
                                    input logic [7:0] off);
      return addr[IIC_ADDR_W-1:2] == off[7:2];
   endfunction : iic_hit

endpackage : iic_pkg

// ---- src/iic_sync.sv ----
// Purpose: Two-stage synchroniser for the asynchronous input lines.
// Assumes: Inputs come from pins outside the core clock domain.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ns
module iic_sync import iic_pkg::*; #(
   parameter int WIDTH = IIC_INPUTS
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else if (ce) begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule : iic_sync

// ---- src/iic_axil.sv ----
// Purpose: AXI4-Lite slave front end turning bus traffic into strobes.
// Assumes: One write and one read outstanding at most.
// Notes:   Address and data of a write are taken in either order.
`timescale 1ns/1ns
module iic_axil import iic_pkg::*; (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Write address and data
   input wire logic [IIC_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [IIC_DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // Write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read address and data
   input wire logic [IIC_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [IIC_DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Register side
   output iic_wr_type wr,
   output logic wr_pulse,
   input wire logic wr_err,
   output logic [IIC_ADDR_W-1:0] rd_addr,
   output logic rd_pulse,
   input wire logic [IIC_DATA_W-1:0] rd_data,
   input wire logic rd_err
);

   logic aw_full_reg;
   logic w_full_reg;
   logic bvalid_reg;
   logic rvalid_reg;
   logic [1:0] bresp_reg;
   logic [1:0] rresp_reg;
   logic [IIC_DATA_W-1:0] rdata_reg;
   iic_wr_type wr_reg;

   // ==========================================================
   // Handshakes; nothing is accepted while the clock enable is low
   assign awready = ce && !aw_full_reg && !bvalid_reg;
   assign wready = ce && !w_full_reg && !bvalid_reg;
   assign wr_pulse = ce && aw_full_reg && w_full_reg && !bvalid_reg;
   assign arready = ce && !rvalid_reg;
   assign rd_pulse = arvalid && arready;
   assign rd_addr = araddr;
   assign wr = wr_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_full_reg <= 1'b0;
         wr_reg.addr <= '0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_full_reg <= 1'b1;
            wr_reg.addr <= awaddr;
         end else if (wr_pulse) begin
            aw_full_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         w_full_reg <= 1'b0;
         wr_reg.data <= '0;
         wr_reg.strb <= '0;
      end else if (ce) begin
         if (wvalid && wready) begin
            w_full_reg <= 1'b1;
            wr_reg.data <= wdata;
            wr_reg.strb <= wstrb;
         end else if (wr_pulse) begin
            w_full_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= IIC_RESP_OKAY;
      end else if (ce) begin
         if (wr_pulse) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_err ? IIC_RESP_SLVERR : IIC_RESP_OKAY;
         end else if (bvalid_reg && bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= IIC_RESP_OKAY;
         rdata_reg <= '0;
      end else if (ce) begin
         if (rd_pulse) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_err ? IIC_RESP_SLVERR : IIC_RESP_OKAY;
            rdata_reg <= rd_data;
         end else if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign rvalid = rvalid_reg;
   assign rresp = rresp_reg;
   assign rdata = rdata_reg;

endmodule : iic_axil

// ---- src/iic_top.sv ----
// Purpose: Interrupt source selection, clearing and status for an
//          isolated digital input bank, reached over AXI4-Lite.
// Assumes: Input lines are asynchronous pins; one 20 MHz core clock.
// Notes:   Rising edges act at core rate; change detection at the
//          8.25 MHz sample rate made by a phase accumulator.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module iic_top import iic_pkg::*; #(
   parameter int INPUTS = IIC_INPUTS
) (
   // Clock, reset, enable
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic CLK_EN,
   // Input pins
   input wire logic [INPUTS-1:0] INPUT_LINE,
   // AXI4-Lite write channels
   input wire logic [IIC_ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [IIC_DATA_W-1:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read channels
   input wire logic [IIC_ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [IIC_DATA_W-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Interrupt
   output logic IRQ
);

   // ==========================================================
   // Declarations
   logic [INPUTS-1:0] level;
   logic [INPUTS-1:0] level_prev_reg;
   logic [INPUTS-1:0] sample_reg;
   logic [INPUTS-1:0] sample_prev_reg;
   logic [INPUTS-1:0] change_channel_mask_reg;
   logic [INPUTS-1:0] change_capture_value_reg;
   logic [INPUTS-1:0] change_capture_value_next;
   logic [IIC_PHASE_W-1:0] phase_reg;
   logic [IIC_PHASE_W-1:0] phase_sum;
   logic sample_tick;
   logic sample_valid_reg;
   iic_src_type irq_enable_reg;
   iic_src_type active_mode;
   iic_src_type flag_reg;
   iic_src_type flag_next;
   iic_src_type flag_set;
   iic_src_type clear_req;
   iic_src_type irq_mask_reg;
   iic_src_type event_reg;
   iic_src_type event_next;
   logic irq_reg;
   iic_wr_type wr;
   logic wr_pulse;
   logic wr_err;
   logic [IIC_ADDR_W-1:0] rd_addr;
   logic rd_pulse;
   logic [IIC_DATA_W-1:0] rd_data;
   logic rd_err;
   logic [IIC_DATA_W-1:0] wr_merged_ctrl;
   logic [IIC_DATA_W-1:0] wr_merged_mask;
   logic [IIC_DATA_W-1:0] wr_merged_imask;
   logic [IIC_DATA_W-1:0] wr_clear_bits;

   // ==========================================================
   // Bus front end
   iic_axil u_axil (
      .clk(CORE_CLK),
      .rst(RESET),
      .ce(CLK_EN),
      .awaddr(S_AXI_AWADDR),
      .awvalid(S_AXI_AWVALID),
      .awready(S_AXI_AWREADY),
      .wdata(S_AXI_WDATA),
      .wstrb(S_AXI_WSTRB),
      .wvalid(S_AXI_WVALID),
      .wready(S_AXI_WREADY),
      .bresp(S_AXI_BRESP),
      .bvalid(S_AXI_BVALID),
      .bready(S_AXI_BREADY),
      .araddr(S_AXI_ARADDR),
      .arvalid(S_AXI_ARVALID),
      .arready(S_AXI_ARREADY),
      .rdata(S_AXI_RDATA),
      .rresp(S_AXI_RRESP),
      .rvalid(S_AXI_RVALID),
      .rready(S_AXI_RREADY),
      .wr(wr),
      .wr_pulse(wr_pulse),
      .wr_err(wr_err),
      .rd_addr(rd_addr),
      .rd_pulse(rd_pulse),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   // ==========================================================
   // Input synchroniser
   iic_sync #(
      .WIDTH(INPUTS)
   ) u_sync (
      .clk(CORE_CLK),
      .rst(RESET),
      .ce(CLK_EN),
      .async_in(INPUT_LINE),
      .sync_out(level)
   );

   // ==========================================================
   // Sample rate generator
   // A phase accumulator gives 33 ticks every 80 clocks, an average of
   // 8.25 MHz; tick spacing jitters between two and three clocks.
   assign phase_sum = phase_reg + IIC_PHASE_W'(IIC_SAMPLE_KHZ); // R11
   assign sample_tick = phase_sum >= IIC_PHASE_W'(IIC_CLK_KHZ); // R11

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         phase_reg <= '0;
      end else if (CLK_EN) begin
         if (sample_tick) begin
            phase_reg <= phase_sum - IIC_PHASE_W'(IIC_CLK_KHZ);
         end else begin
            phase_reg <= phase_sum;
         end
      end
   end

   // Sampled levels; the first sample after reset is judged against the zero reset history
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         sample_reg <= '0;
         sample_prev_reg <= '0;
         sample_valid_reg <= 1'b0;
      end else if (CLK_EN && sample_tick) begin
         sample_reg <= level; // R11
         sample_prev_reg <= sample_reg;
         sample_valid_reg <= 1'b1;
      end
   end

   // Edge history for the rising-edge sources
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         level_prev_reg <= '0;
      end else if (CLK_EN) begin
         level_prev_reg <= level;
      end
   end

   // ==========================================================
   // Source decode and request generation
   assign active_mode = iic_decode_mode(irq_enable_reg); // R1

   always_comb begin
      flag_set = '0;
      // Change is judged between consecutive samples, only on masked bits
      flag_set.change = active_mode.change && sample_valid_reg &&
         |((sample_reg ^ sample_prev_reg) &
           change_channel_mask_reg); // R2 R12
      flag_set.input0 = active_mode.input0 &&
         level[0] && !level_prev_reg[0]; // R3
      flag_set.input1 = active_mode.input1 &&
         level[1] && !level_prev_reg[1]; // R4
   end

   // Clear bits act only where software writes a one
   assign wr_clear_bits = iic_apply_strb('0, wr.data, wr.strb);
   assign clear_req = (wr_pulse && iic_hit(wr.addr, IIC_OFF_CLEAR)) ?
      iic_src_type'(wr_clear_bits[2:0]) : '0; // R5 R6 R7 R8

   // A new request in the clearing cycle survives the clear
   assign flag_next = flag_set | (flag_reg & ~clear_req); // R5 R6 R7 R8

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         flag_reg <= '0;
      end else if (CLK_EN) begin
         flag_reg <= flag_next; // R9
      end
   end

   // ==========================================================
   // Change capture
   // Only the first change of a pending request is captured, so software
   // sees the levels that actually raised the interrupt.
   always_comb begin
      change_capture_value_next = change_capture_value_reg;
      if (clear_req.change) begin
         change_capture_value_next = '0; // R10
      end
      if (flag_set.change && (!flag_reg.change || clear_req.change)) begin
         change_capture_value_next = sample_reg; // R10
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         change_capture_value_reg <= '0;
      end else if (CLK_EN) begin
         change_capture_value_reg <= change_capture_value_next;
      end
   end

   // ==========================================================
   // Software registers
   assign wr_merged_ctrl = iic_apply_strb(
      IIC_DATA_W'(irq_enable_reg), wr.data, wr.strb);
   assign wr_merged_mask = iic_apply_strb(
      IIC_DATA_W'(change_channel_mask_reg), wr.data, wr.strb);
   assign wr_merged_imask = iic_apply_strb(
      IIC_DATA_W'(irq_mask_reg), wr.data, wr.strb);

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         irq_enable_reg <= IIC_CTRL_RESET;
      end else if (CLK_EN && wr_pulse && iic_hit(wr.addr, IIC_OFF_CTRL)) begin
         irq_enable_reg <= iic_src_type'(wr_merged_ctrl[2:0]); // R1
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         change_channel_mask_reg <= '0;
      end else if (CLK_EN && wr_pulse &&
                   iic_hit(wr.addr, IIC_OFF_CHG_MASK)) begin
         change_channel_mask_reg <= wr_merged_mask[INPUTS-1:0]; // R12
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         irq_mask_reg <= IIC_IRQ_MASK_RESET;
      end else if (CLK_EN && wr_pulse &&
                   iic_hit(wr.addr, IIC_OFF_IRQ_MASK)) begin
         irq_mask_reg <= iic_src_type'(wr_merged_imask[2:0]);
      end
   end

   // Sticky event log; a read clears it, but a new event still wins
   always_comb begin
      event_next = event_reg;
      if (rd_pulse && iic_hit(rd_addr, IIC_OFF_IRQ_EVENT)) begin
         event_next = '0;
      end
      event_next = event_next | flag_set;
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         event_reg <= '0;
      end else if (CLK_EN) begin
         event_reg <= event_next;
      end
   end

   // ==========================================================
   // Interrupt output
   // Registered so the pin is glitch free; it trails the flags by a cycle.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         irq_reg <= 1'b0;
      end else if (CLK_EN) begin
         irq_reg <= |(flag_reg & irq_mask_reg); // R13
      end
   end

   assign IRQ = irq_reg;

   // ==========================================================
   // Read mux and address errors
   always_comb begin
      rd_data = '0;
      rd_err = 1'b0;
      case (rd_addr[IIC_ADDR_W-1:2])
         IIC_OFF_CTRL[7:2]: begin
            rd_data = IIC_DATA_W'(irq_enable_reg);
         end
         IIC_OFF_CLEAR[7:2]: begin
            rd_data = '0;
         end
         IIC_OFF_FLAGS[7:2]: begin
            rd_data = IIC_DATA_W'(flag_reg); // R9
         end
         IIC_OFF_CHG_MASK[7:2]: begin
            rd_data = IIC_DATA_W'(change_channel_mask_reg);
         end
         IIC_OFF_CAPTURE[7:2]: begin
            rd_data = IIC_DATA_W'(change_capture_value_reg); // R10
         end
         IIC_OFF_LEVEL[7:2]: begin
            rd_data = IIC_DATA_W'(level);
         end
         IIC_OFF_IRQ_MASK[7:2]: begin
            rd_data = IIC_DATA_W'(irq_mask_reg);
         end
         IIC_OFF_IRQ_EVENT[7:2]: begin
            rd_data = IIC_DATA_W'(event_reg);
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

   // Writes to read-only or unmapped words answer with an error
   always_comb begin
      wr_err = 1'b1;
      if (iic_hit(wr.addr, IIC_OFF_CTRL) ||
          iic_hit(wr.addr, IIC_OFF_CLEAR) ||
          iic_hit(wr.addr, IIC_OFF_CHG_MASK) ||
          iic_hit(wr.addr, IIC_OFF_IRQ_MASK)) begin
         wr_err = 1'b0;
      end
   end

endmodule : iic_top

// ---- tb/iic_top_asserts.sv ----
// Purpose: Port-level checks of the register bus and the interrupt line.
// Assumes: One clock domain; RESET is asynchronous and active high.
// Notes:   Bound into every instance of the top module.
`timescale 1ns/1ns
module iic_top_chk import iic_pkg::*; (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET,
   // Bus handshakes
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [IIC_DATA_W-1:0] S_AXI_RDATA,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Interrupt
   input wire logic IRQ
);
   // ==========================================================
   // Properties
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   chk_b_hold: assert property (
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped early");
   chk_r_hold: assert property (
      S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
      else $error("read answer dropped early");
   chk_r_answer: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   chk_w_answer: assert property (
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##[2:3] S_AXI_BVALID)
      else $error("write response late");
   chk_ar_block: assert property (
      S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read taken while answer pending");
   chk_aw_block: assert property (
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken while response pending");
   chk_r_drop: assert property (
      S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("read answer repeated");
   chk_b_drop: assert property (
      S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
      else $error("write response repeated");
   chk_reset_idle: assert property (
      $fell(RESET) |-> !S_AXI_BVALID && !S_AXI_RVALID && !IRQ)
      else $error("outputs busy after reset");
endmodule : iic_top_chk

bind iic_top iic_top_chk i_iic_top_chk (.*);

// ---- tb/iic_host.sv ----
// Purpose: Host model issuing single AXI4-Lite writes and reads.
// Assumes: Driven by task calls from the bench, one access at a time.
// Notes:   Released address and data show the inverse, never old values.
`timescale 1ns/1ns
module iic_host import iic_pkg::*; (
   // Clock
   input wire logic CORE_CLK,
   // Write channels
   output logic [IIC_ADDR_W-1:0] S_AXI_AWADDR,
   output logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   output logic [IIC_DATA_W-1:0] S_AXI_WDATA,
   output logic [3:0] S_AXI_WSTRB,
   output logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   output logic S_AXI_BREADY,
   // Read channels
   output logic [IIC_ADDR_W-1:0] S_AXI_ARADDR,
   output logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   output logic S_AXI_RREADY,
   // Status
   output logic hang
);
   initial begin
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, hang} = 4'h0;
      {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR} = '0;
      S_AXI_WDATA = '0;
      S_AXI_WSTRB = 4'h0;
   end

   // ==========================================================
   // Accesses; readiness is sampled at the falling edge to avoid races
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge CORE_CLK);
      {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_WSTRB} <= {a, d, 4'hf};
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h6;
      for (int n = 0; n < 100 && !tb; n++) begin
         @(negedge CORE_CLK);
         ta = S_AXI_AWVALID && S_AXI_AWREADY;
         tw = S_AXI_WVALID && S_AXI_WREADY;
         tb = S_AXI_BVALID && S_AXI_BREADY;
         @(posedge CORE_CLK);
         if (ta) {S_AXI_AWVALID, S_AXI_AWADDR} <= {1'b0, ~a};
         if (tw) {S_AXI_WVALID, S_AXI_WDATA} <= {1'b0, ~d};
         if (!tb) S_AXI_BREADY <= S_AXI_BVALID;
      end
      S_AXI_BREADY <= 1'b0;
      if (!tb) hang <= 1'b1;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      tr = 1'b0;
      @(posedge CORE_CLK);
      {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'h2};
      for (int n = 0; n < 100 && !tr; n++) begin
         @(negedge CORE_CLK);
         ta = S_AXI_ARVALID && S_AXI_ARREADY;
         tr = S_AXI_RVALID && S_AXI_RREADY;
         @(posedge CORE_CLK);
         if (ta) {S_AXI_ARVALID, S_AXI_ARADDR} <= {1'b0, ~a};
         if (!tr) S_AXI_RREADY <= S_AXI_RVALID;
      end
      S_AXI_RREADY <= 1'b0;
      if (!tr) hang <= 1'b1;
   endtask : rd
endmodule : iic_host

// ---- tb/iic_top_tb.sv ----
// Purpose: Self-checking bench for the interrupt control block.
// Assumes: The host model drives the bus; the bench drives the pins.
// Notes:   Expected answers wait in a queue until the bus returns them.
`timescale 1ns/1ns
module iic_top_tb import iic_pkg::*;;
   logic CORE_CLK = 1'b0;
   logic RESET = 1'b1;
   logic CLK_EN = 1'b1;
   logic [15:0] INPUT_LINE = 16'h0000;
   logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, lf;
   logic [3:0] S_AXI_WSTRB;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
   logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
   logic S_AXI_RVALID, S_AXI_RREADY, IRQ, hang;
   logic [15:0] pat, mk;
   logic [2:0] ex, im, c;
   logic [33:0] q[$];
   int n_mismatch = 0;
   int checks = 0;

   always #25 CORE_CLK = ~CORE_CLK;

   iic_top i_iic_top (.*);
   iic_host i_iic_host (.*);

   // ==========================================================
   // Helpers
   function automatic logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nx

   task automatic cmp(input logic [33:0] g, input logic [33:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp

   task automatic rq(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
      q.push_back({r, e});
      i_iic_host.rd(a);
   endtask : rq

   task automatic wq(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      q.push_back({r, 32'h0000_0000});
      i_iic_host.wr(a, d);
   endtask : wq

   task automatic wrap_up();
      $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   // Answers are judged where the host takes them
   always @(negedge CORE_CLK) begin
      if (S_AXI_RVALID && S_AXI_RREADY)
         cmp({S_AXI_RRESP, S_AXI_RDATA}, q.pop_front());
      if (S_AXI_BVALID && S_AXI_BREADY)
         cmp({S_AXI_BRESP, 32'h0000_0000}, q.pop_front());
      if (hang) begin
         n_mismatch++;
         wrap_up();
      end
   end

   // ==========================================================
   // Sequence
   initial begin
      lf = 32'hedf2_10f0;
      repeat (16) @(posedge CORE_CLK);
      RESET <= 1'b0;
      rq(IIC_OFF_CTRL, 32'h0000_0000, 2'h0);
      rq(IIC_OFF_IRQ_MASK, 32'h0000_0007, 2'h0);
      rq(IIC_OFF_CHG_MASK, 32'h0000_0000, 2'h0);
      rq(8'h20, 32'h0000_0000, 2'h2);
      wq(IIC_OFF_FLAGS, 32'h0000_0001, 2'h2);
      wq(8'h40, 32'h0000_0001, 2'h2);
      $display("Test reset and map done");
      for (int m = 0; m < 8; m++) begin
         c = 3'(m);
         wq(IIC_OFF_CTRL, 32'h0000_0000, 2'h0);
         INPUT_LINE <= 16'h0000;
         repeat (8) @(posedge CORE_CLK);
         wq(IIC_OFF_CLEAR, 32'h0000_0007, 2'h0);
         lf = nx(lf);
         mk = lf[15:0];
         im = lf[18:16];
         wq(IIC_OFF_CHG_MASK, {16'h0000, mk}, 2'h0);
         wq(IIC_OFF_IRQ_MASK, {29'h0, im}, 2'h0);
         wq(IIC_OFF_CTRL, {29'h0, c}, 2'h0);
         lf = nx(lf);
         pat = lf[15:0] | 16'h0003;
         ex = (c == 3'h1) ? {2'b00, |(pat & mk)} :
              (c[0] ? 3'h0 : {c[2], c[1], 1'b0});
         @(posedge CORE_CLK);
         INPUT_LINE <= pat;
         repeat (10) @(posedge CORE_CLK);
         rq(IIC_OFF_LEVEL, {16'h0000, pat}, 2'h0);
         rq(IIC_OFF_FLAGS, {29'h0, ex}, 2'h0);
         rq(IIC_OFF_CAPTURE, ex[0] ? {16'h0000, pat} : 32'h0, 2'h0);
         cmp({33'h0, IRQ}, {33'h0, |(ex & im)});
         rq(IIC_OFF_IRQ_EVENT, {29'h0, ex}, 2'h0);
         rq(IIC_OFF_IRQ_EVENT, 32'h0000_0000, 2'h0);
         wq(IIC_OFF_CLEAR, 32'h0000_0000, 2'h0);
         rq(IIC_OFF_FLAGS, {29'h0, ex}, 2'h0);
         for (int b = 0; b < 3; b++) begin
            wq(IIC_OFF_CLEAR, 32'h0000_0001 << b, 2'h0);
            ex[b] = 1'b0;
            rq(IIC_OFF_FLAGS, {29'h0, ex}, 2'h0);
         end
         rq(IIC_OFF_CAPTURE, 32'h0000_0000, 2'h0);
         $display("Test mode %0d done", m);
      end
      repeat (4) @(posedge CORE_CLK);
      wrap_up();
   end
endmodule : iic_top_tb
